// ### core/spwp_params.svh
// constants for the serial wiper position block
`ifndef SPWP_PARAMS_SVH
`define SPWP_PARAMS_SVH
`define SPWP_CODE_W 8
`define SPWP_TAPS 256
`define SPWP_SHIFT_RESET 8'h00
`define SPWP_WIPER_RESET 8'h80
`endif

// ### core/spwp_pkg.sv
// types for the serial wiper position block
`include "spwp_params.svh"
package spwp_pkg;
    typedef logic [`SPWP_CODE_W-1:0] spwp_code_t;
    typedef struct packed {
        logic valid;
        spwp_code_t code;
    } spwp_update_t;
endpackage

// ### core/spwp_tap_decode.sv
// one-hot tap decoder driven from a register
`timescale 1ns/1ps
`include "spwp_params.svh"
module spwp_tap_decode #(
    parameter int TAPS = `SPWP_TAPS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire spwp_pkg::spwp_code_t code_i,
    output logic [TAPS-1:0] tap_sel_o
);
    // elaboration check: one tap per code value
    if (TAPS != (1 << `SPWP_CODE_W))
    begin : g_bad_taps
        $error("tap count must match code width");
    end

    // **********************************
    // decode
    // **********************************
    // one flop per tap, exactly one high
    for (genvar g = 0; g < TAPS; g++)
    begin : g_tap
        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
                tap_sel_o[g] <= (g == int'(`SPWP_WIPER_RESET));
            else
                tap_sel_o[g] <= (code_i == spwp_pkg::spwp_code_t'(g));
        end
    end

    one_tap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot(tap_sel_o)) else $error("tap select not one-hot");
endmodule

// ### core/spwp_wiper.sv
// serial wiper position logic with a link clock domain
// Overview of operation
// - wiper holds midscale after power-up until chip select rises
// - power-up clears input register, wiper to 0x80
// - chip select rising copies input register to wiper
// - transfer happens even without new shifted bits
// - wiper code selects one of 256 taps
// - code zero is bottom; top never selected
// - shift data on serial clock rise while selected
// - only last eight shifted bits kept
`timescale 1ns/1ps
`include "spwp_params.svh"
module spwp_wiper #(
    parameter int TAPS = `SPWP_TAPS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_data_in_i,
    output spwp_pkg::spwp_code_t wiper_code_o,
    output logic [TAPS-1:0] tap_sel_o
);
    // **********************************
    // parameter check
    // **********************************
    // the decoder needs exactly one tap per code value
    if (TAPS != (1 << `SPWP_CODE_W))
    begin : g_bad_taps
        $error("tap count must match code width");
    end

    // three clocks meet here: the serial clock shifts, the chip select
    // rise captures, the system clock owns the wiper; the captured word
    // stands still while its toggle crosses, so no gray code is needed,
    // provided chip select stays high for a few system clocks
    // **********************************
    // link domain: shift register
    // **********************************
    spwp_pkg::spwp_code_t shift_q;
    logic load_tgl_q;

    // shift msb first, oldest bits fall off the top
    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
            shift_q <= `SPWP_SHIFT_RESET;
        else if (!cs_n_i)
            shift_q <= {shift_q[`SPWP_CODE_W-2:0], serial_data_in_i};
    end

    // **********************************
    // transfer on chip select rise
    // **********************************
    // chip select rise captures the word and flags it by a toggle
    spwp_pkg::spwp_code_t xfer_q;
    always_ff @(posedge cs_n_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            xfer_q <= `SPWP_SHIFT_RESET;
            load_tgl_q <= 1'b0;
        end
        else
        begin
            xfer_q <= shift_q;
            load_tgl_q <= ~load_tgl_q;
        end
    end

    // **********************************
    // system domain
    // **********************************
    logic [2:0] tgl_sync_q;
    spwp_pkg::spwp_update_t upd;
    spwp_pkg::spwp_code_t wiper_q;

    // toggle synchroniser plus edge stage
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tgl_sync_q <= 3'h0;
        else
            tgl_sync_q <= {tgl_sync_q[1:0], load_tgl_q};
    end

    // word held stable since the toggle, safe to sample now
    always_comb
    begin
        upd.valid = tgl_sync_q[2] ^ tgl_sync_q[1];
        upd.code = xfer_q;
    end

    // wiper register, midscale at power-up
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            wiper_q <= `SPWP_WIPER_RESET;
        else if (upd.valid)
            wiper_q <= upd.code;
    end

    assign wiper_code_o = wiper_q;

    spwp_tap_decode #(
        .TAPS(TAPS)
    ) u_decode (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i(wiper_q),
        .tap_sel_o(tap_sel_o)
    );

    // **********************************
    // checks
    // **********************************
    // wiper only moves on a transfer pulse
    wiper_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !upd.valid |=> $stable(wiper_q)
    )
    else
        $error("wiper moved without transfer");

    // a transfer pulse loads the captured word
    wiper_load_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd.valid |=> wiper_q == $past(xfer_q)
    )
    else
        $error("wiper not loaded");

    // one toggle gives a single pulse
    pulse_single_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd.valid |=> !upd.valid
    )
    else
        $error("transfer pulse too long");

    // captured word stands while its toggle crosses
    xfer_stable_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd.valid |-> $stable(xfer_q)
    )
    else
        $error("captured word moved during crossing");

    // tap select follows the wiper one clock later
    tap_match_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 tap_sel_o[$past(wiper_q)]
    )
    else
        $error("wrong tap");

    // code zero lands on the bottom terminal
    tap_bottom_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wiper_q == '0 |=> tap_sel_o[0]
    )
    else
        $error("code zero not at bottom");

    // full code is the last tap, one step short of the top
    tap_top_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wiper_q == '1 |=> tap_sel_o[TAPS-1] && !tap_sel_o[0]
    )
    else
        $error("full code not at last tap");

    // deselected serial clock leaves the shift register alone
    shift_idle_a: assert property (
        @(posedge sclk_i) disable iff (rst_i)
        cs_n_i |=> $stable(shift_q)
    )
    else
        $error("shift while deselected");

    // newest bit enters at the bottom
    shift_in_a: assert property (
        @(posedge sclk_i) disable iff (rst_i)
        !cs_n_i |=> shift_q[0] == $past(serial_data_in_i)
    )
    else
        $error("bad shift");

    // oldest bit falls off the top
    shift_drop_a: assert property (
        @(posedge sclk_i) disable iff (rst_i)
        !cs_n_i |=> shift_q[7:1] == $past(shift_q[6:0])
    )
    else
        $error("bad drop");

    // every chip select rise captures the shift register
    xfer_copy_a: assert property (
        @(posedge cs_n_i) disable iff (rst_i)
        ##1 xfer_q == $past(shift_q)
    )
    else
        $error("shift register not captured");
endmodule

// ### testbench/spwp_master.sv
// far-side serial master model for the wiper block
`timescale 1ns/1ps
module spwp_master (
    output logic sclk_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic sdo_o = 1'b0
);
    // n bits msb first on a 32 ns clock, which stands low outside frames
    task automatic send(input logic [15:0] w, input int n, input logic sel);
        cs_n_o = !sel;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdo_o = w[i];
            #16 sclk_o = 1'b1;
            #16 sclk_o = 1'b0;
            sdo_o = ~w[i]; // data no longer held after the hold time
        end
        #16 cs_n_o = 1'b1;
    endtask
endmodule

// ### testbench/spi_wiper_position_control_bench.sv
// self-checking bench for the serial wiper position block
`timescale 1ns/1ps
`define CHK(a, e) \
    begin n_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module spi_wiper_position_control_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk, cs_n, serial_data_in;
    logic [31:0] seed = 32'hBF7C;
    int num_errors = 0;
    int n_checks = 0;
    spwp_pkg::spwp_code_t code;
    logic [255:0] taps;
    // design and its far-side master
    spwp_wiper DUT (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .serial_data_in_i(serial_data_in), .wiper_code_o(code), .tap_sel_o(taps));
    spwp_master host (.sclk_o(sclk), .cs_n_o(cs_n), .sdo_o(serial_data_in));
    // next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // let the crossing settle, then compare code and one-hot tap
    task automatic expect_code(input logic [7:0] e);
        repeat (8) @(negedge clk_i);
        `CHK(code, e)
        `CHK(taps, 256'h1 << e)
        $display("test done, code %h", e);
    endtask
    task automatic give_verdict;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // system clock, 25 ns
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    // hang guard
    initial
    begin
        #100000;
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        expect_code(8'h80);
        host.send(16'h00FF, 8, 1'b0);
        expect_code(8'h80);
        host.send(16'h0000, 0, 1'b1);
        expect_code(8'h00);
        host.send(16'h00FF, 8, 1'b1);
        expect_code(8'hFF);
        repeat (6)
        begin
            seed = lfsr(seed);
            host.send(seed[15:0], 8, 1'b1);
            expect_code(seed[7:0]);
        end
        host.send(16'h0A5C, 12, 1'b1);
        expect_code(8'h5C);
        // second power-up in mid-run
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        expect_code(8'h80);
        host.send(16'h0000, 0, 1'b1);
        expect_code(8'h00);
        give_verdict();
    end
endmodule
